// *** rtl/sss_pkg.sv ***
// Constants, register map and carrier types of the safe-stop supervisor.
package sss_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int SPD_W = 16;
    localparam int CFG_W = 16;
    localparam int T_W = 18;
    localparam int FRAC = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CFG_BASE = 8'h08;
    localparam int CFG_N = 10;
    localparam logic [ADDR_W-1:0] OFF_CFG_END = 8'h30;

    // Control register bits.
    localparam int CTRL_W = 7;
    localparam int CB_LIMIT_EN = 0;
    localparam int CB_QUICK_EN = 1;
    localparam int CB_RESTART_ONE = 2;
    localparam int CB_BRAKE_EN = 3;
    localparam int CB_INST_TWO = 4;
    localparam int CB_CTRL_BRAKED = 5;
    localparam int CB_RESTART_TWO = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // Status register: writing one to this bit clears the latched fault.
    localparam int SB_FAULT = 7;

    // Configuration word indices; delays are in safety-cycle ticks.
    localparam int CI_MON_START = 0;
    localparam int CI_RAMP_TIME = 1;
    localparam int CI_OVERRUN = 2;
    localparam int CI_RAMP_MON = 3;
    localparam int CI_TORQUE_OFF = 4;
    localparam int CI_RAMP_START = 5;
    localparam int CI_FACTOR = 6;
    localparam int CI_OFFSET = 7;
    localparam int CI_MARGIN = 8;
    localparam int CI_BRAKE_DELAY = 9;

    typedef logic [CFG_W-1:0] sss_cfg_t;
    localparam sss_cfg_t CFG_RST [CFG_N] = '{16'h0002, 16'h0064, 16'h0002, 16'h0001, 16'h0001,
                                             16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0064};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_RAMP = 2'b10,
        ST_SAFE = 2'b11
    } sss_state_e;

    typedef struct packed {
        logic limit_valid;
        logic quick_stop;
        logic [SPD_W-1:0] limit;
    } sss_drive_cmd_s;

    typedef struct packed {
        logic hold_stop_request;
        logic torque_off;
        logic brake;
    } sss_safety_s;

endpackage

// *** rtl/sss_safe_stop_supervisor.sv ***
// Safe-stop supervisor: request handling, timed slowdown ramp, monitoring and hand-over.
module sss_safe_stop_supervisor (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cycle_tick,
    input wire logic i_request_in,
    input wire logic i_error_request,
    input wire logic i_clear_in,
    input wire logic i_standstill,
    input wire logic signed [sss_pkg::SPD_W-1:0] i_actual_speed,
    input wire logic [sss_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sss_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [sss_pkg::DATA_W-1:0] o_rdata,
    output logic o_requested,
    output logic o_safe_reached,
    output logic o_fault,
    output sss_pkg::sss_drive_cmd_s o_drive_cmd,
    output sss_pkg::sss_safety_s o_safety
);

    localparam logic [sss_pkg::T_W-1:0] T_MAX = '1;

    logic [sss_pkg::CTRL_W-1:0] ctrl_q;
    sss_pkg::sss_cfg_t cfg_q [sss_pkg::CFG_N];
    logic active_q;
    logic active_d;
    logic [sss_pkg::T_W-1:0] t_q;
    logic [sss_pkg::CFG_W-1:0] n_max_q;
    logic [sss_pkg::CFG_W-1:0] n_max_d;
    logic [sss_pkg::SPD_W-1:0] limit_q;
    logic [sss_pkg::DATA_W-1:0] debt_q;
    logic [sss_pkg::CFG_W-1:0] viol_cnt_q;
    logic fault_q;
    sss_pkg::sss_state_e phase_q;
    sss_pkg::sss_state_e phase_d;
    logic [sss_pkg::DATA_W-1:0] rd_val;
    logic req_any;
    logic cancel;
    logic start;
    logic inst_two;
    logic ctrl_braked;
    logic clr_fault;
    logic [sss_pkg::SPD_W-1:0] abs_spd;
    logic [sss_pkg::DATA_W-1:0] prod;
    logic [sss_pkg::SPD_W:0] scaled;
    logic [sss_pkg::T_W-1:0] ramp_start_at;
    logic [sss_pkg::T_W-1:0] ramp_end_at;
    logic [sss_pkg::T_W-1:0] mon_at;
    logic [sss_pkg::T_W-1:0] torque_at;
    logic [sss_pkg::T_W-1:0] safe_at;
    logic [sss_pkg::CFG_W-1:0] ramp_len;
    logic ramping;
    logic mon_on;
    logic outside;
    logic [sss_pkg::ADDR_W-1:0] cfg_off;
    logic cfg_hit;

    assign inst_two = ctrl_q[sss_pkg::CB_INST_TWO];
    assign ctrl_braked = ctrl_q[sss_pkg::CB_CTRL_BRAKED];
    assign clr_fault = i_wr && (i_addr == sss_pkg::OFF_STATUS) && i_wdata[sss_pkg::SB_FAULT];

    // Register port: control, status and the configuration words.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_q <= sss_pkg::CTRL_RST;
        end else if (i_wr && i_addr == sss_pkg::OFF_CTRL) begin
            ctrl_q <= i_wdata[sss_pkg::CTRL_W-1:0];
        end
    end

    generate
        for (genvar gi = 0; gi < sss_pkg::CFG_N; gi++) begin : g_cfg
            localparam logic [sss_pkg::ADDR_W-1:0] OFF = sss_pkg::ADDR_W'(sss_pkg::OFF_CFG_BASE + 4 * gi);
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    cfg_q[gi] <= sss_pkg::CFG_RST[gi];
                end else if (i_wr && i_addr == OFF) begin
                    cfg_q[gi] <= i_wdata[sss_pkg::CFG_W-1:0];
                end
            end
        end
    endgenerate

    assign cfg_off = i_addr - sss_pkg::OFF_CFG_BASE;
    assign cfg_hit = (i_addr >= sss_pkg::OFF_CFG_BASE) && (i_addr < sss_pkg::OFF_CFG_END) && (i_addr[1:0] == 2'h0);

    always_comb begin
        rd_val = '0;
        if (i_addr == sss_pkg::OFF_CTRL) begin
            rd_val = sss_pkg::DATA_W'(ctrl_q);
        end else if (i_addr == sss_pkg::OFF_STATUS) begin
            rd_val = sss_pkg::DATA_W'({phase_q, fault_q, o_safe_reached, o_requested, o_safety.hold_stop_request,
                                       o_safety.torque_off, o_safety.brake, o_drive_cmd.quick_stop,
                                       o_drive_cmd.limit_valid});
        end else if (cfg_hit) begin
            rd_val = sss_pkg::DATA_W'(cfg_q[4'(cfg_off >> 2)]);
        end
    end

    // Unmapped reads return zero; the data stand only in the cycle after the strobe.
    always_ff @(posedge i_clk) begin
        if (i_srst || !i_rd) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= rd_val;
        end
    end

    // A pending request always beats both the clear input and automatic restart.
    assign req_any = i_request_in || i_error_request;
    assign cancel = !req_any && (i_clear_in ||
                    (inst_two ? ctrl_q[sss_pkg::CB_RESTART_TWO] : ctrl_q[sss_pkg::CB_RESTART_ONE]));
    assign active_d = active_q ? !cancel : req_any;
    assign start = req_any && !active_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active_d;
        end
    end

    // Elapsed safety-cycle ticks since the request; zero while idle.
    always_ff @(posedge i_clk) begin
        if (i_srst || !active_q) begin
            t_q <= '0;
        end else if (i_cycle_tick && t_q != T_MAX) begin
            t_q <= t_q + 1'b1;
        end
    end

    assign ramp_start_at = sss_pkg::T_W'(cfg_q[sss_pkg::CI_RAMP_START]);
    assign ramp_end_at = sss_pkg::T_W'(cfg_q[sss_pkg::CI_RAMP_TIME]);
    assign mon_at = sss_pkg::T_W'(ramp_start_at + cfg_q[sss_pkg::CI_RAMP_MON]);
    assign torque_at = sss_pkg::T_W'(ramp_end_at +
                       (ctrl_q[sss_pkg::CB_BRAKE_EN] ? cfg_q[sss_pkg::CI_TORQUE_OFF] : '0));
    assign safe_at = sss_pkg::T_W'((inst_two ? ramp_end_at : torque_at) + cfg_q[sss_pkg::CI_RAMP_MON]);
    assign ramp_len = (cfg_q[sss_pkg::CI_RAMP_TIME] > cfg_q[sss_pkg::CI_RAMP_START]) ?
                      sss_pkg::CFG_W'(cfg_q[sss_pkg::CI_RAMP_TIME] - cfg_q[sss_pkg::CI_RAMP_START]) :
                      sss_pkg::CFG_W'(1);
    assign ramping = (t_q >= ramp_start_at) && (t_q < ramp_end_at);

    // Ramp start speed from the speed seen at the request, saturated to full scale.
    assign abs_spd = i_actual_speed[sss_pkg::SPD_W-1] ? sss_pkg::SPD_W'(-i_actual_speed) : sss_pkg::SPD_W'(i_actual_speed);
    // Both operands are widened first so that the product keeps its upper bits.
    assign prod = sss_pkg::DATA_W'(abs_spd) * sss_pkg::DATA_W'(cfg_q[sss_pkg::CI_FACTOR]);
    assign scaled = sss_pkg::CFG_W'(prod >> sss_pkg::FRAC) + {1'b0, cfg_q[sss_pkg::CI_OFFSET]};
    assign n_max_d = (|(prod >> (sss_pkg::FRAC + sss_pkg::SPD_W)) || scaled[sss_pkg::SPD_W]) ?
                     '1 : scaled[sss_pkg::SPD_W-1:0];

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            n_max_q <= '0;
        end else if (start) begin
            n_max_q <= n_max_d;
        end
    end

    // The ramp falls by n_max over ramp_len ticks: each tick adds n_max to a debt that is
    // paid off one speed step per clock. This avoids a divider but assumes the tick period
    // in clocks is at least n_max divided by ramp_len.
    always_ff @(posedge i_clk) begin
        if (i_srst || !active_d) begin
            limit_q <= '0;
            debt_q <= '0;
        end else if (start) begin
            limit_q <= n_max_d;
            debt_q <= '0;
        end else if (t_q >= ramp_end_at) begin
            limit_q <= '0;
            debt_q <= '0;
        end else if (i_cycle_tick && ramping) begin
            debt_q <= sss_pkg::DATA_W'(debt_q + n_max_q);
        end else if (debt_q >= sss_pkg::DATA_W'(ramp_len) && limit_q != '0) begin
            debt_q <= sss_pkg::DATA_W'(debt_q - ramp_len);
            limit_q <= limit_q - 1'b1;
        end
    end

    // Monitoring waits for both the start delay and the sent-value settle delay.
    assign mon_on = active_q && (t_q >= sss_pkg::T_W'(cfg_q[sss_pkg::CI_MON_START])) && (t_q >= mon_at);
    assign outside = mon_on && (abs_spd > limit_q);

    always_ff @(posedge i_clk) begin
        if (i_srst || !outside) begin
            viol_cnt_q <= '0;
        end else if (i_cycle_tick && viol_cnt_q != '1) begin
            viol_cnt_q <= viol_cnt_q + 1'b1;
        end
    end

    // Set beats the software clear so an excursion in the clear cycle is never lost.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fault_q <= 1'b0;
        end else if (outside && i_cycle_tick && viol_cnt_q >= cfg_q[sss_pkg::CI_OVERRUN]) begin
            fault_q <= 1'b1;
        end else if (clr_fault) begin
            fault_q <= 1'b0;
        end
    end
    assign o_fault = fault_q;

    always_comb begin
        phase_d = sss_pkg::ST_IDLE;
        case (1'b1)
            !active_d: begin
                phase_d = sss_pkg::ST_IDLE;
            end
            start || t_q < ramp_start_at: begin
                phase_d = sss_pkg::ST_DELAY;
            end
            t_q < safe_at: begin
                phase_d = sss_pkg::ST_RAMP;
            end
            default: begin
                phase_d = sss_pkg::ST_SAFE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            phase_q <= sss_pkg::ST_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Status flags and hand-over to the dependent safety functions.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_requested <= 1'b0;
            o_safe_reached <= 1'b0;
            o_safety <= '0;
        end else begin
            o_requested <= active_d;
            o_safe_reached <= active_d && active_q && t_q >= safe_at;
            o_safety.hold_stop_request <= active_d && active_q && inst_two && t_q >= safe_at;
            o_safety.torque_off <= active_d && active_q && !inst_two && t_q >= torque_at;
            o_safety.brake <= active_d && active_q && !inst_two && ctrl_q[sss_pkg::CB_BRAKE_EN] &&
                              (i_standstill || t_q >= sss_pkg::T_W'(cfg_q[sss_pkg::CI_BRAKE_DELAY]));
        end
    end

    // In controller-braked mode the basic unit is left alone (no quick stop, no limit_valid); status and safety hand-over still run.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_drive_cmd <= '0;
        end else begin
            o_drive_cmd.quick_stop <= active_d && ctrl_q[sss_pkg::CB_QUICK_EN] && !ctrl_braked;
            o_drive_cmd.limit_valid <= active_d && ctrl_q[sss_pkg::CB_LIMIT_EN] && !ctrl_braked;
            o_drive_cmd.limit <= (limit_q > cfg_q[sss_pkg::CI_MARGIN]) ?
                                 sss_pkg::SPD_W'(limit_q - cfg_q[sss_pkg::CI_MARGIN]) : '0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    property p_req_taken;
        start |=> o_requested && active_q;
    endproperty
    a_req_taken: assert property (p_req_taken) else $error("request not taken");

    property p_clear_ignored;
        active_q && req_any |=> active_q && o_requested;
    endproperty
    a_clear_ignored: assert property (p_clear_ignored) else $error("request lost while pending");

    property p_clear;
        active_q && !req_any && i_clear_in |=> !o_requested ##1 t_q == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not end the stop");

    property p_no_early_mon;
        active_q && t_q < sss_pkg::T_W'(cfg_q[sss_pkg::CI_MON_START]) |-> !outside && viol_cnt_q == '0;
    endproperty
    a_no_early_mon: assert property (p_no_early_mon) else $error("monitoring before start delay");

    property p_ramp_end;
        active_q && active_d && t_q >= ramp_end_at |=> limit_q == '0;
    endproperty
    a_ramp_end: assert property (p_ramp_end) else $error("ramp still running after ramp time");

    property p_fault_cause;
        $rose(fault_q) |-> $past(viol_cnt_q) >= $past(cfg_q[sss_pkg::CI_OVERRUN]) && $past(outside);
    endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("fault without long excursion");

    property p_fault_latch;
        fault_q && !clr_fault |=> fault_q;
    endproperty
    a_fault_latch: assert property (p_fault_latch) else $error("fault dropped by itself");

    property p_quick;
        start && ctrl_q[sss_pkg::CB_QUICK_EN] && !ctrl_braked |=> o_drive_cmd.quick_stop;
    endproperty
    a_quick: assert property (p_quick) else $error("quick stop not asserted at request");

    property p_hold_drop;
        active_q && !active_d |=> !o_safety.hold_stop_request && !o_safe_reached;
    endproperty
    a_hold_drop: assert property (p_hold_drop) else $error("operating stop kept after end");

    property p_safe_time;
        $rose(o_safe_reached) |-> $past(t_q) >= $past(safe_at);
    endproperty
    a_safe_time: assert property (p_safe_time) else $error("safe state flagged too early");

    property p_margin;
        o_drive_cmd.limit_valid |-> o_drive_cmd.limit <= $past(limit_q);
    endproperty
    a_margin: assert property (p_margin) else $error("sent limit above monitoring limit");

    property p_brake;
        active_q && active_d && !inst_two && ctrl_q[sss_pkg::CB_BRAKE_EN] && i_standstill |=> o_safety.brake;
    endproperty
    a_brake: assert property (p_brake) else $error("brake not applied at standstill");

endmodule

// *** tb/sss_drive_model.sv ***
// Behavioural basic drive unit and functional controller facing the supervisor.
module sss_drive_model (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire sss_pkg::sss_drive_cmd_s i_cmd,
    input wire logic i_hold,
    input wire logic i_ctrl_brake,
    input wire logic signed [sss_pkg::SPD_W-1:0] i_set,
    output logic signed [sss_pkg::SPD_W-1:0] o_speed,
    output logic o_standstill
);
    timeunit 1ns;
    timeprecision 1ps;
    // A real axle cannot stop at once, so braking removes one speed step per clock.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_speed <= 16'sh0000;
        end else if (i_hold) begin
            o_speed <= i_set;
        end else if (i_cmd.quick_stop && o_speed > 0) begin
            o_speed <= o_speed - 16'sh0001;
        end else if (i_ctrl_brake && o_speed > 0) begin
            o_speed <= o_speed - 16'sh0001;
        end else if (i_cmd.limit_valid && o_speed > $signed(i_cmd.limit)) begin
            o_speed <= $signed(i_cmd.limit);
        end
    end
    assign o_standstill = (o_speed == 16'sh0000);
endmodule

// *** tb/sss_safe_stop_supervisor_tb.sv ***
// Self-checking bench of the safe-stop supervisor with a drive-unit model.
module sss_safe_stop_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_srst, i_request_in, i_error_request, i_clear_in, i_wr, i_rd;
    logic i_cycle_tick = 1'b0;
    logic [4:0] tick_cnt = 5'h00;
    logic [sss_pkg::ADDR_W-1:0] i_addr;
    logic [sss_pkg::DATA_W-1:0] i_wdata, o_rdata, d;
    logic o_requested, o_safe_reached, o_fault, standstill, hold, ctrl_brake;
    logic signed [sss_pkg::SPD_W-1:0] speed, set_spd;
    sss_pkg::sss_drive_cmd_s o_drive_cmd;
    sss_pkg::sss_safety_s o_safety;
    int error_cnt, cmp_count, cycles;

    sss_safe_stop_supervisor DUT (.i_clk(i_clk), .i_srst(i_srst), .i_cycle_tick(i_cycle_tick),
        .i_request_in(i_request_in), .i_error_request(i_error_request), .i_clear_in(i_clear_in),
        .i_standstill(standstill), .i_actual_speed(speed), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_requested(o_requested),
        .o_safe_reached(o_safe_reached), .o_fault(o_fault), .o_drive_cmd(o_drive_cmd), .o_safety(o_safety));
    sss_drive_model u_drive (.i_clk(i_clk), .i_srst(i_srst), .i_cmd(o_drive_cmd), .i_hold(hold),
        .i_ctrl_brake(ctrl_brake), .i_set(set_spd), .o_speed(speed), .o_standstill(standstill));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // A tick every 32 clocks keeps the ramp step of the design within one step per clock in every test but t_limits.
    always @(posedge i_clk) begin
        tick_cnt <= tick_cnt + 5'h01;
        i_cycle_tick <= (tick_cnt == 5'h1f);
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    function automatic logic [31:0] bit_of(input int n);
        return 32'h1 << n;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        d = o_rdata;
    endtask

    task automatic cfg(input int i, input logic [15:0] v);
        wr(sss_pkg::OFF_CFG_BASE + 8'(4 * i), {16'h0000, v});
    endtask

    task automatic rst(input int n);
        i_srst <= 1'b1;
        repeat (n) @(posedge i_clk);
        i_srst <= 1'b0;
        i_request_in <= 1'b0;
        i_error_request <= 1'b0;
        i_clear_in <= 1'b0;
        hold <= 1'b1;
        set_spd <= 16'sh0000;
        ctrl_brake <= 1'b0;
    endtask

    // Raises a request just after a tick so that tick counting starts cleanly.
    task automatic start(input logic err);
        do @(posedge i_clk); while (i_cycle_tick !== 1'b1);
        if (err) begin
            i_error_request <= 1'b1;
        end else begin
            i_request_in <= 1'b1;
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            do @(posedge i_clk); while (i_cycle_tick !== 1'b1);
        end
        repeat (3) @(posedge i_clk);
    endtask

    task automatic t_regs();
        rst(2);
        for (int i = 0; i < sss_pkg::CFG_N; i++) begin
            rd(sss_pkg::OFF_CFG_BASE + 8'(4 * i));
            chk(d, {16'h0000, sss_pkg::CFG_RST[i]});
        end
        rd(8'h40);
        chk(d, 32'h0);
        wr(sss_pkg::OFF_CTRL, 32'h0000007f);
        rd(sss_pkg::OFF_CTRL);
        chk(d, 32'h7f);
        @(posedge i_clk);
        chk(o_rdata, 32'h0);
    endtask

    task automatic t_stop_two();
        rst(2);
        wr(sss_pkg::OFF_CTRL, bit_of(sss_pkg::CB_INST_TWO));
        cfg(sss_pkg::CI_RAMP_TIME, 16'h0006);
        cfg(sss_pkg::CI_RAMP_MON, 16'h0002);
        start(1'b0);
        @(posedge i_clk);
        chk(32'(o_requested), 32'h0);
        @(posedge i_clk);
        chk(32'(o_requested), 32'h1);
        ticks(7);
        chk(32'(o_safe_reached), 32'h0);
        chk(32'(o_safety.hold_stop_request), 32'h0);
        ticks(1);
        chk(32'(o_safe_reached), 32'h1);
        chk(32'(o_safety.hold_stop_request), 32'h1);
        rd(sss_pkg::OFF_STATUS);
        chk(d, 32'h00000370);
        i_clear_in <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk(32'(o_requested), 32'h1);
        i_request_in <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(32'(o_requested), 32'h0);
        chk(32'(o_safety.hold_stop_request), 32'h0);
    endtask

    task automatic t_limits();
        rst(2);
        wr(sss_pkg::OFF_CTRL, bit_of(sss_pkg::CB_LIMIT_EN) | bit_of(sss_pkg::CB_QUICK_EN) |
            bit_of(sss_pkg::CB_RESTART_ONE));
        cfg(sss_pkg::CI_OFFSET, 16'h0010);
        cfg(sss_pkg::CI_MARGIN, 16'h0008);
        cfg(sss_pkg::CI_RAMP_START, 16'h0003);
        cfg(sss_pkg::CI_RAMP_TIME, 16'h0006);
        set_spd <= 16'sh0064;
        start(1'b1);
        repeat (2) @(posedge i_clk);
        hold <= 1'b0;
        chk(32'(o_drive_cmd.quick_stop), 32'h1);
        chk(32'(o_drive_cmd.limit_valid), 32'h1);
        ticks(2);
        chk(32'(o_drive_cmd.limit), 32'h6c);
        ticks(3);
        chk(32'(o_safety.torque_off), 32'h0);
        ticks(1);
        chk(32'(o_safety.torque_off), 32'h1);
        chk(32'(o_drive_cmd.limit), 32'h0);
        i_error_request <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(32'(o_requested), 32'h0);
        chk(32'(o_drive_cmd.quick_stop), 32'h0);
    endtask

    task automatic t_fault();
        rst(2);
        wr(sss_pkg::OFF_CTRL, bit_of(sss_pkg::CB_INST_TWO));
        cfg(sss_pkg::CI_MON_START, 16'h0004);
        cfg(sss_pkg::CI_FACTOR, 16'h0080);
        set_spd <= 16'sh0064;
        start(1'b0);
        ticks(5);
        chk(32'(o_fault), 32'h0);
        ticks(2);
        chk(32'(o_fault), 32'h1);
        set_spd <= 16'sh0000;
        ticks(2);
        chk(32'(o_fault), 32'h1);
        rd(sss_pkg::OFF_STATUS);
        chk(32'(d[sss_pkg::SB_FAULT]), 32'h1);
        wr(sss_pkg::OFF_STATUS, bit_of(sss_pkg::SB_FAULT));
        repeat (2) @(posedge i_clk);
        chk(32'(o_fault), 32'h0);
    endtask

    task automatic t_brake();
        rst(2);
        wr(sss_pkg::OFF_CTRL, bit_of(sss_pkg::CB_BRAKE_EN));
        cfg(sss_pkg::CI_RAMP_TIME, 16'h0006);
        cfg(sss_pkg::CI_TORQUE_OFF, 16'h0003);
        cfg(sss_pkg::CI_BRAKE_DELAY, 16'h0002);
        set_spd <= 16'sh0010;
        start(1'b0);
        repeat (3) @(posedge i_clk);
        chk(32'(o_safety.brake), 32'h0);
        set_spd <= 16'sh0000;
        repeat (3) @(posedge i_clk);
        chk(32'(o_safety.brake), 32'h1);
        set_spd <= 16'sh0010;
        ticks(2);
        chk(32'(o_safety.brake), 32'h1);
        set_spd <= 16'sh0000;
        ticks(6);
        chk(32'(o_safety.torque_off), 32'h0);
        ticks(1);
        chk(32'(o_safety.torque_off), 32'h1);
        chk(32'(o_safe_reached), 32'h0);
        ticks(1);
        chk(32'(o_safe_reached), 32'h1);
    endtask

    task automatic t_restart();
        rst(2);
        wr(sss_pkg::OFF_CTRL, bit_of(sss_pkg::CB_INST_TWO) | bit_of(sss_pkg::CB_RESTART_TWO) |
            bit_of(sss_pkg::CB_CTRL_BRAKED) | bit_of(sss_pkg::CB_QUICK_EN));
        cfg(sss_pkg::CI_RAMP_TIME, 16'h0006);
        cfg(sss_pkg::CI_RAMP_MON, 16'h0002);
        start(1'b0);
        ticks(3);
        i_request_in <= 1'b0;
        set_spd <= 16'sh0032;
        repeat (3) @(posedge i_clk);
        chk(32'(o_requested), 32'h0);
        ctrl_brake <= 1'b1;
        start(1'b0);
        repeat (2) @(posedge i_clk);
        hold <= 1'b0;
        chk(32'(o_requested), 32'h1);
        chk(32'(o_drive_cmd.quick_stop), 32'h0);
        ticks(7);
        chk(32'(o_safe_reached), 32'h0);
        ticks(1);
        chk(32'(o_safe_reached), 32'h1);
        chk(32'(o_safety.hold_stop_request), 32'h1);
    endtask

    initial begin
        error_cnt = 0;
        cmp_count = 0;
        cycles = 0;
        i_srst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_request_in = 1'b0;
        i_error_request = 1'b0;
        i_clear_in = 1'b0;
        hold = 1'b1;
        set_spd = 16'sh0000;
        ctrl_brake = 1'b0;
        rst(16);
        t_regs();
        $display("Register test finished");
        t_stop_two();
        $display("Second instance test finished");
        t_limits();
        $display("Limit and quick stop test finished");
        t_fault();
        $display("Fault test finished");
        t_brake();
        $display("Brake test finished");
        t_restart();
        $display("Restart test finished");
        stop_test();
    end
endmodule
